/* File: common/linefeed_pkg.sv */
// constants, types and helpers for the linefeed state and dc feed bank
// assumes a single 250 MHz clock domain and an 8-bit register port

package linefeed_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] ADDR_LINEFEED = 8'h40;
   localparam logic [7:0] ADDR_CUR_LIMIT = 8'h47;
   localparam logic [7:0] ADDR_OPEN_V = 8'h48;
   localparam logic [7:0] ADDR_COMMON_V = 8'h49;
   localparam logic [7:0] ADDR_LOOP_V = 8'h4e;
   localparam logic [7:0] ADDR_LOOP_I = 8'h4f;

   // ****************************************
   // field layout and reset values
   // ****************************************
   localparam int STATE_LSB = 0;
   localparam int STATE_ACT_LSB = 4;
   localparam int CUR_LIMIT_W = 3;
   localparam int VOLT_CODE_W = 6;
   localparam int ADC_W = 7;
   localparam logic [2:0] STATE_RST = 3'h0;
   localparam logic [2:0] CUR_LIMIT_RST = 3'h0;
   localparam logic [5:0] OPEN_V_RST = 6'h20;
   localparam logic [5:0] COMMON_V_RST = 6'h02;

   // ****************************************
   // linefeed state codes
   // ****************************************
   localparam logic [2:0] CODE_OPEN = 3'h0;
   localparam logic [2:0] CODE_FWD_ACT = 3'h1;
   localparam logic [2:0] CODE_FWD_OHT = 3'h2;
   localparam logic [2:0] CODE_TIP_OPEN = 3'h3;
   localparam logic [2:0] CODE_RINGING = 3'h4;
   localparam logic [2:0] CODE_REV_ACT = 3'h5;
   localparam logic [2:0] CODE_REV_OHT = 3'h6;
   localparam logic [2:0] CODE_RING_OPEN = 3'h7;

   typedef enum logic [7:0] {
      MODE_OPEN = 8'h01,
      MODE_FWD_ACT = 8'h02,
      MODE_FWD_OHT = 8'h04,
      MODE_TIP_OPEN = 8'h08,
      MODE_RINGING = 8'h10,
      MODE_REV_ACT = 8'h20,
      MODE_REV_OHT = 8'h40,
      MODE_RING_OPEN = 8'h80
   } feed_mode_t;

   // ****************************************
   // scaling and timing
   // ****************************************
   localparam logic [5:0] CUR_BASE_MA = 6'h14;
   localparam logic [5:0] CUR_STEP_MA = 6'h03;
   localparam logic [9:0] VOLT_STEP_DV = 10'h00f;
   localparam int CLK_HZ = 250000000;
   localparam int SAMPLE_RATE_HZ = 800;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
   localparam int CNT_W = 19;

   // three-bit code to one-hot mode
   function automatic feed_mode_t mode_decode(input logic [2:0] code);
      feed_mode_t m;
      m = MODE_OPEN;
      unique case (code)
         CODE_OPEN: m = MODE_OPEN;
         CODE_FWD_ACT: m = MODE_FWD_ACT;
         CODE_FWD_OHT: m = MODE_FWD_OHT;
         CODE_TIP_OPEN: m = MODE_TIP_OPEN;
         CODE_RINGING: m = MODE_RINGING;
         CODE_REV_ACT: m = MODE_REV_ACT;
         CODE_REV_OHT: m = MODE_REV_OHT;
         CODE_RING_OPEN: m = MODE_RING_OPEN;
      endcase
      return m;
   endfunction

   // 6-bit voltage code to tenths of a volt
   function automatic logic [9:0] code_to_dv(input logic [5:0] code);
      logic [15:0] p;
      p = {10'h000, code} * {6'h00, VOLT_STEP_DV};
      return p[9:0];
   endfunction

   // current limit code to milliamps
   function automatic logic [5:0] limit_to_ma(input logic [2:0] code);
      logic [11:0] p;
      p = {9'h000, code} * {6'h00, CUR_STEP_MA};
      return CUR_BASE_MA + p[5:0];
   endfunction

endpackage

/* File: common/monitor_if.sv */
// carries monitored samples and fault events from the sampler to the bank
// assumes both ends run on mclk

`timescale 1ns/1ns

interface monitor_if;
   logic sample_tick;
   logic [6:0] loop_voltage;
   logic [6:0] loop_current;
   logic power_fault;

   modport sampler(output sample_tick, output loop_voltage, output loop_current, output power_fault);
   modport consumer(input sample_tick, input loop_voltage, input loop_current, input power_fault);
endinterface

/* File: hdl/line_monitor.sv */
// synchronises converter words and the power comparator, refreshes samples
// assumes converter outputs and fault pin are asynchronous to mclk

`timescale 1ns/1ns

module line_monitor #(
   parameter int SAMPLE_PERIOD = linefeed_pkg::SAMPLE_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic [linefeed_pkg::ADC_W-1:0] adc_loop_voltage,
   input wire logic [linefeed_pkg::ADC_W-1:0] adc_loop_current,
   input wire logic power_fault_pin,
   monitor_if.sampler mon
);
   import linefeed_pkg::*;

   typedef struct packed {
      logic [ADC_W-1:0] v_s1;
      logic [ADC_W-1:0] v_s2;
      logic [ADC_W-1:0] i_s1;
      logic [ADC_W-1:0] i_s2;
      logic f_s1;
      logic f_s2;
      logic f_s3;
      logic [CNT_W-1:0] cnt;
      logic [ADC_W-1:0] v_smp;
      logic [ADC_W-1:0] i_smp;
      logic tick;
      logic fault;
   } mon_state_t;

   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_PERIOD - 1);

   mon_state_t state_reg;
   mon_state_t state_next;

   // ****************************************
   // next state
   // ****************************************
   // sync chains, 800 Hz refresh, fault rising edge
   always_comb begin
      state_next = state_reg;
      state_next.v_s1 = adc_loop_voltage;
      state_next.v_s2 = state_reg.v_s1;
      state_next.i_s1 = adc_loop_current;
      state_next.i_s2 = state_reg.i_s1;
      state_next.f_s1 = power_fault_pin;
      state_next.f_s2 = state_reg.f_s1;
      state_next.f_s3 = state_reg.f_s2;
      state_next.fault = state_reg.f_s2 & ~state_reg.f_s3;
      state_next.tick = 1'b0;
      if (state_reg.cnt == CNT_LAST) begin
         state_next.cnt = '0;
         state_next.v_smp = state_reg.v_s2;
         state_next.i_smp = state_reg.i_s2;
         state_next.tick = 1'b1;
      end else begin
         state_next.cnt = state_reg.cnt + 1'b1;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   // freezes while ce is low
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign mon.sample_tick = state_reg.tick;
   assign mon.loop_voltage = state_reg.v_smp;
   assign mon.loop_current = state_reg.i_smp;
   assign mon.power_fault = state_reg.fault;
endmodule

/* File: hdl/linefeed_ctrl.sv */
// linefeed state and dc feed register bank with driver controls
// assumes a same-clock register port; converter and fault inputs are async

`timescale 1ns/1ns

module linefeed_ctrl #(
   parameter int SAMPLE_PERIOD = linefeed_pkg::SAMPLE_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [linefeed_pkg::ADC_W-1:0] adc_loop_voltage,
   input wire logic [linefeed_pkg::ADC_W-1:0] adc_loop_current,
   input wire logic power_fault_pin,
   input wire logic auto_open_enable,
   input wire logic alarm_irq_enable,
   input wire logic power_alarm_clear,
   output logic power_alarm,
   output logic power_alarm_irq,
   output logic sample_tick,
   output logic tip_drive_en,
   output logic ring_drive_en,
   output logic audio_path_en,
   output logic ringing_en,
   output logic reverse_polarity,
   output logic [9:0] open_circuit_voltage_dv,
   output logic [5:0] loop_current_limit_ma,
   output logic [10:0] tip_level_dv,
   output logic [10:0] ring_level_dv
);
   import linefeed_pkg::*;

   typedef struct packed {
      logic [2:0] linefeed_state_field;
      logic [CUR_LIMIT_W-1:0] loop_current_limit;
      logic [VOLT_CODE_W-1:0] open_circuit_voltage;
      logic [VOLT_CODE_W-1:0] common_mode_voltage;
      logic alarm;
      logic [7:0] rdata;
      logic tip_en;
      logic ring_en;
      logic audio_en;
      logic ring_gen;
      logic reverse;
      logic [9:0] open_dv;
      logic [5:0] limit_ma;
      logic [10:0] tip_dv;
      logic [10:0] ring_dv;
   } bank_state_t;

   bank_state_t state_reg;
   bank_state_t state_next;
   feed_mode_t mode;

   monitor_if mon();

   // ****************************************
   // sampler
   // ****************************************
   line_monitor #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) u_monitor (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .adc_loop_voltage(adc_loop_voltage),
      .adc_loop_current(adc_loop_current),
      .power_fault_pin(power_fault_pin),
      .mon(mon.sampler)
   );

   // ****************************************
   // next state
   // ****************************************
   // register writes, alarm, mode decode and driver controls
   always_comb begin
      logic [9:0] cm_dv;
      cm_dv = '0;
      state_next = state_reg;

      // software writes; settings take effect on the same edge
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_LINEFEED: state_next.linefeed_state_field = reg_wdata[STATE_LSB +: 3];
            ADDR_CUR_LIMIT: state_next.loop_current_limit = reg_wdata[CUR_LIMIT_W-1:0];
            ADDR_OPEN_V: state_next.open_circuit_voltage = reg_wdata[VOLT_CODE_W-1:0];
            ADDR_COMMON_V: state_next.common_mode_voltage = reg_wdata[VOLT_CODE_W-1:0];
            default: ;
         endcase
      end

      // alarm: set wins over clear; auto-open overrides a same-cycle write
      if (power_alarm_clear) begin
         state_next.alarm = 1'b0;
      end
      if (mon.power_fault) begin
         state_next.alarm = 1'b1;
         if (auto_open_enable) begin
            state_next.linefeed_state_field = CODE_OPEN;
         end
      end

      // read data, unmapped offsets read as zero
      state_next.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_LINEFEED: begin
               state_next.rdata[STATE_LSB +: 3] = state_reg.linefeed_state_field;
               state_next.rdata[STATE_ACT_LSB +: 3] = state_reg.linefeed_state_field;
            end
            ADDR_CUR_LIMIT: state_next.rdata[CUR_LIMIT_W-1:0] = state_reg.loop_current_limit;
            ADDR_OPEN_V: state_next.rdata[VOLT_CODE_W-1:0] = state_reg.open_circuit_voltage;
            ADDR_COMMON_V: state_next.rdata[VOLT_CODE_W-1:0] = state_reg.common_mode_voltage;
            ADDR_LOOP_V: state_next.rdata[ADC_W-1:0] = mon.loop_voltage;
            ADDR_LOOP_I: state_next.rdata[ADC_W-1:0] = mon.loop_current;
            default: ;
         endcase
      end

      // driver controls from the new state code
      mode = mode_decode(state_next.linefeed_state_field);
      state_next.tip_en = 1'b0;
      state_next.ring_en = 1'b0;
      state_next.audio_en = 1'b0;
      state_next.ring_gen = 1'b0;
      state_next.reverse = 1'b0;
      unique case (mode)
         MODE_OPEN: ;
         MODE_FWD_ACT: begin
            state_next.tip_en = 1'b1;
            state_next.ring_en = 1'b1;
         end
         MODE_FWD_OHT: begin
            state_next.tip_en = 1'b1;
            state_next.ring_en = 1'b1;
            state_next.audio_en = 1'b1;
         end
         MODE_TIP_OPEN: state_next.ring_en = 1'b1;
         MODE_RINGING: begin
            state_next.tip_en = 1'b1;
            state_next.ring_en = 1'b1;
            state_next.ring_gen = 1'b1;
         end
         MODE_REV_ACT: begin
            state_next.tip_en = 1'b1;
            state_next.ring_en = 1'b1;
            state_next.reverse = 1'b1;
         end
         MODE_REV_OHT: begin
            state_next.tip_en = 1'b1;
            state_next.ring_en = 1'b1;
            state_next.audio_en = 1'b1;
            state_next.reverse = 1'b1;
         end
         MODE_RING_OPEN: state_next.tip_en = 1'b1;
      endcase

      // feed targets, magnitudes below ground in tenths of a volt
      state_next.open_dv = code_to_dv(state_next.open_circuit_voltage);
      state_next.limit_ma = limit_to_ma(state_next.loop_current_limit);
      cm_dv = code_to_dv(state_next.common_mode_voltage);
      if (state_next.reverse) begin
         state_next.ring_dv = {1'b0, cm_dv};
         state_next.tip_dv = {1'b0, cm_dv} + {1'b0, state_next.open_dv};
      end else begin
         state_next.tip_dv = {1'b0, cm_dv};
         state_next.ring_dv = {1'b0, cm_dv} + {1'b0, state_next.open_dv};
      end
   end

   // ****************************************
   // registers
   // ****************************************
   // reset leaves the line open with default feed codes
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         state_reg <= '0;
         state_reg.linefeed_state_field <= STATE_RST;
         state_reg.loop_current_limit <= CUR_LIMIT_RST;
         state_reg.open_circuit_voltage <= OPEN_V_RST;
         state_reg.common_mode_voltage <= COMMON_V_RST;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // outputs straight from flops, except power_alarm_irq, which gates the alarm flop with alarm_irq_enable
   assign reg_rdata = state_reg.rdata;
   assign power_alarm = state_reg.alarm;
   assign power_alarm_irq = state_reg.alarm & alarm_irq_enable;
   assign sample_tick = mon.sample_tick;
   assign tip_drive_en = state_reg.tip_en;
   assign ring_drive_en = state_reg.ring_en;
   assign audio_path_en = state_reg.audio_en;
   assign ringing_en = state_reg.ring_gen;
   assign reverse_polarity = state_reg.reverse;
   assign open_circuit_voltage_dv = state_reg.open_dv;
   assign loop_current_limit_ma = state_reg.limit_ma;
   assign tip_level_dv = state_reg.tip_dv;
   assign ring_level_dv = state_reg.ring_dv;
endmodule

/* File: bench/linefeed_ctrl_checker.sv */
// assertions on the linefeed bank ports
// assumes one mclk domain with sync active-low reset
`timescale 1ns/1ns
module linefeed_ctrl_checker
   import linefeed_pkg::*;
#(
   parameter int SAMPLE_PERIOD = 16
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ce,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic power_fault_pin,
   input wire logic auto_open_enable,
   input wire logic alarm_irq_enable,
   input wire logic power_alarm_clear,
   input wire logic power_alarm,
   input wire logic power_alarm_irq,
   input wire logic sample_tick,
   input wire logic tip_drive_en,
   input wire logic ring_drive_en,
   input wire logic audio_path_en,
   input wire logic ringing_en,
   input wire logic reverse_polarity,
   input wire logic [5:0] loop_current_limit_ma
);
   // ****
   // helper logic
   // ****
   int gap_reg;
   logic seen_reg;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   // cycles between sample ticks
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         gap_reg <= 0;
         seen_reg <= 1'b0;
      end else if (ce && sample_tick) begin
         gap_reg <= 0;
         seen_reg <= 1'b1;
      end else if (ce) begin
         gap_reg <= gap_reg + 1;
      end
   end
   sequence s_state_wr(logic [2:0] c);
      ce && reg_wr && reg_addr == ADDR_LINEFEED && reg_wdata[2:0] == c && !auto_open_enable;
   endsequence
   // fault pin edge as seen on mclk
   sequence s_fault_edge;
      $rose(power_fault_pin);
   endsequence
   // ****
   // assertions
   // ****
   a_open_drives_off: assert property (s_state_wr(CODE_OPEN) |=>
      !tip_drive_en && !ring_drive_en && !audio_path_en && !ringing_en) else $error("open state left a drive on");
   a_oht_audio_on: assert property (s_state_wr(CODE_FWD_OHT) |=>
      tip_drive_en && ring_drive_en && audio_path_en && !reverse_polarity) else $error("on-hook state wrong");
   a_ringing_gen_on: assert property (s_state_wr(CODE_RINGING) |=>
      ringing_en && !audio_path_en) else $error("ringing state wrong");
   a_irq_gate: assert property (power_alarm_irq == (power_alarm && alarm_irq_enable))
      else $error("alarm irq not gated");
   a_alarm_holds: assert property (power_alarm && !power_alarm_clear |=> power_alarm)
      else $error("alarm dropped without clear");
   a_auto_open_now: assert property ($rose(power_alarm) && auto_open_enable |->
      !tip_drive_en && !ring_drive_en) else $error("fault did not open line");
   a_fault_sets_alarm: assert property (s_fault_edge |-> ##[1:6] power_alarm)
      else $error("fault edge gave no alarm");
   a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data without read");
   a_limit_scale: assert property (ce && reg_wr && reg_addr == ADDR_CUR_LIMIT |=>
      loop_current_limit_ma == 6'h14 + 6'h03 * {3'h0, $past(reg_wdata[2:0])}) else $error("limit scaling");
   a_tick_gap: assert property (ce && sample_tick && seen_reg |-> gap_reg == SAMPLE_PERIOD - 1)
      else $error("sample period wrong");
endmodule
bind linefeed_ctrl linefeed_ctrl_checker #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) u_chk (.mclk(mclk), .resetn(resetn),
   .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .power_fault_pin(power_fault_pin), .auto_open_enable(auto_open_enable), .alarm_irq_enable(alarm_irq_enable),
   .power_alarm_clear(power_alarm_clear), .power_alarm(power_alarm), .power_alarm_irq(power_alarm_irq),
   .sample_tick(sample_tick), .tip_drive_en(tip_drive_en), .ring_drive_en(ring_drive_en),
   .audio_path_en(audio_path_en), .ringing_en(ringing_en), .reverse_polarity(reverse_polarity),
   .loop_current_limit_ma(loop_current_limit_ma));

/* File: bench/line_partner.sv */
// model of the external line transistors and sense path
// assumes enables and levels come straight from the bank
`timescale 1ns/1ns
module line_partner (
   input wire logic tip_drive_en,
   input wire logic ring_drive_en,
   input wire logic [10:0] tip_level_dv,
   input wire logic [10:0] ring_level_dv,
   input wire logic overload,
   output logic [6:0] adc_loop_voltage,
   output logic [6:0] adc_loop_current,
   output logic power_fault_pin
);
   // open line floats: no voltage, no current, no stress
   always_comb begin
      adc_loop_voltage = 7'h00;
      adc_loop_current = 7'h00;
      if (tip_drive_en && ring_drive_en) begin
         adc_loop_voltage = {1'b0, 6'((ring_level_dv - tip_level_dv) / 11'd15)};
         adc_loop_current = overload ? 7'h10 : 7'h08;
      end
      power_fault_pin = overload && (tip_drive_en || ring_drive_en);
   end
endmodule

/* File: bench/tb_linefeed_ctrl.sv */
// self-checking bench for the linefeed bank
// assumes the line partner model and bound checker
`timescale 1ns/1ns
module tb_linefeed_ctrl;
   import linefeed_pkg::*;
   logic mclk, resetn, ce, reg_wr, reg_rd, auto_open_enable, alarm_irq_enable, power_alarm_clear, overload;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic power_alarm, power_alarm_irq, sample_tick, tip_drive_en, ring_drive_en, audio_path_en;
   logic ringing_en, reverse_polarity, power_fault_pin;
   logic [9:0] open_circuit_voltage_dv;
   logic [5:0] loop_current_limit_ma;
   logic [10:0] tip_level_dv, ring_level_dv;
   logic [6:0] adc_loop_voltage, adc_loop_current;
   int n_mismatch = 0;
   int check_count = 0;
   logic [4:0] tbl [8] = '{5'h00, 5'h18, 5'h1c, 5'h08, 5'h1a, 5'h19, 5'h1d, 5'h10};
   linefeed_ctrl #(.SAMPLE_PERIOD(16)) dut (.mclk, .resetn, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .adc_loop_voltage, .adc_loop_current, .power_fault_pin, .auto_open_enable,
      .alarm_irq_enable, .power_alarm_clear, .power_alarm, .power_alarm_irq, .sample_tick, .tip_drive_en,
      .ring_drive_en, .audio_path_en, .ringing_en, .reverse_polarity, .open_circuit_voltage_dv,
      .loop_current_limit_ma, .tip_level_dv, .ring_level_dv);
   line_partner line (.tip_drive_en, .ring_drive_en, .tip_level_dv, .ring_level_dv, .overload,
      .adc_loop_voltage, .adc_loop_current, .power_fault_pin);
   // ****
   // bus and compare tasks
   // ****
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = v;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge mclk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   // polls off the edge so the flag is settled when looked at
   task automatic wait_alarm();
      for (int i = 0; i < 20 && power_alarm !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic close_out();
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_reset();
      rd(ADDR_OPEN_V);
      chk("voc reset", 16'h20, d);
      rd(ADDR_COMMON_V);
      chk("vcm reset", 16'h02, d);
      rd(8'h41);
      chk("unmapped", 16'h00, d);
      chk("voc dv", 16'd480, open_circuit_voltage_dv);
      chk("loop_current_limit ma", 16'd20, loop_current_limit_ma);
   endtask
   task automatic t_feed();
      ce = 1'b0;
      wr(ADDR_CUR_LIMIT, 8'h05);
      ce = 1'b1;
      chk("ce frozen", 16'd20, loop_current_limit_ma);
      wr(ADDR_CUR_LIMIT, 8'hff);
      chk("loop_current_limit max", 16'd41, loop_current_limit_ma);
      rd(ADDR_CUR_LIMIT);
      chk("loop_current_limit read", 16'h07, d);
      wr(ADDR_OPEN_V, 8'h3f);
      chk("voc max", 16'd945, open_circuit_voltage_dv);
      wr(ADDR_COMMON_V, 8'h04);
      wr(8'h41, 8'h55);
      rd(8'h41);
      chk("unmapped wr", 16'h00, d);
   endtask
   task automatic t_states();
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_LINEFEED, {5'h00, 3'(i)});
         chk("drives", {11'h0, tbl[i]}, {11'h0, tip_drive_en, ring_drive_en, audio_path_en, ringing_en,
            reverse_polarity});
         rd(ADDR_LINEFEED);
         chk("state read", {8'h0, 1'b0, 3'(i), 1'b0, 3'(i)}, {8'h0, d});
         if (i == 1) chk("fwd tip", 16'd60, tip_level_dv);
         if (i == 5) chk("rev tip", 16'd1005, tip_level_dv);
         if (i == 5) chk("rev ring", 16'd60, ring_level_dv);
      end
   endtask
   task automatic t_fault();
      wr(ADDR_LINEFEED, 8'h01);
      overload = 1'b1;
      wait_alarm();
      chk("alarm", 16'h1, power_alarm);
      chk("no auto open", 16'h1, tip_drive_en);
      chk("irq masked", 16'h0, power_alarm_irq);
      alarm_irq_enable = 1'b1;
      @(posedge mclk);
      #1;
      chk("irq", 16'h1, power_alarm_irq);
      power_alarm_clear = 1'b1;
      @(posedge mclk);
      #1;
      power_alarm_clear = 1'b0;
      chk("cleared", 16'h0, power_alarm);
      overload = 1'b0;
      auto_open_enable = 1'b1;
      repeat (4) @(posedge mclk);
      #1;
      overload = 1'b1;
      wait_alarm();
      chk("open tip", 16'h0, tip_drive_en);
      chk("open ring", 16'h0, ring_drive_en);
      rd(ADDR_LINEFEED);
      chk("open code", 16'h00, d);
      overload = 1'b0;
      auto_open_enable = 1'b0;
   endtask
   // 32 cycles hold exactly two refresh pulses at a period of 16
   task automatic t_sample();
      int ticks;
      ticks = 0;
      wr(ADDR_LINEFEED, 8'h01);
      repeat (32) begin
         @(posedge mclk);
         #1;
         if (sample_tick === 1'b1) ticks++;
      end
      chk("tick count", 16'd2, 16'(ticks));
      rd(ADDR_LOOP_V);
      chk("loop voltage", 16'h3f, d);
      rd(ADDR_LOOP_I);
      chk("loop current", 16'h08, d);
   endtask
   // ****
   // clock, watchdog, main sequence
   // ****
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // watchdog against a hang
   initial begin
      #80000;
      n_mismatch++;
      close_out();
   end
   // reset then scenarios
   initial begin
      {resetn, reg_wr, reg_rd, auto_open_enable, alarm_irq_enable, power_alarm_clear, overload} = 7'h00;
      ce = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (2) @(posedge mclk);
      #1;
      resetn = 1'b1;
      t_reset();
      t_feed();
      t_states();
      t_fault();
      t_sample();
      close_out();
   end
endmodule
